// ==== dswp_pkg.sv ====
package dswp_pkg;

  // ==========================================================================
  // register map (byte addresses, one aligned word each)
  // ==========================================================================
  localparam logic [11:0] DSWP_CTRL_OFS   = 12'h000;
  localparam logic [11:0] DSWP_STATUS_OFS = 12'h004;
  localparam logic [11:0] DSWP_CODE_OFS   = 12'h008;
  localparam logic [11:0] DSWP_MODE_OFS   = 12'h00C;
  localparam logic [11:0] DSWP_COUNT_OFS  = 12'h010;

  // ==========================================================================
  // frame layout
  // ==========================================================================
  localparam int unsigned DSWP_FRAME_BITS = 16;
  localparam logic [4:0]  DSWP_LAST_BIT   = 5'h10;
  localparam int unsigned DSWP_MODE_HI    = 13;
  localparam int unsigned DSWP_MODE_LO    = 12;
  localparam int unsigned DSWP_CODE_HI    = 11;
  localparam int unsigned DSWP_CODE_W     = 12;
  localparam logic [11:0] DSWP_CODE_RST   = 12'h000;
  localparam int unsigned DSWP_CODE_FULL  = 4096;

  // ==========================================================================
  // control / status fields
  // ==========================================================================
  localparam int unsigned DSWP_CTRL_CLR_BIT  = 0;
  localparam int unsigned DSWP_ST_PD_BIT     = 0;
  localparam int unsigned DSWP_ST_WAKE_BIT   = 1;
  localparam int unsigned DSWP_ST_VALID_BIT  = 2;
  localparam int unsigned DSWP_ST_ACTIVE_BIT = 3;
  localparam int unsigned DSWP_ST_ABORT_BIT  = 4;

  localparam logic [1:0] DSWP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DSWP_RESP_SLVERR = 2'h2;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned DSWP_CLK_MHZ       = 100;
  localparam int unsigned DSWP_WAKE_UP_US    = 39;
  localparam int unsigned DSWP_WAKE_UP_CYC   = DSWP_WAKE_UP_US * DSWP_CLK_MHZ;
  localparam logic [11:0] DSWP_WAKE_UP_CYC_W = 12'(DSWP_WAKE_UP_CYC);

  typedef enum logic [1:0] {
    DSWP_MODE_NORMAL,
    DSWP_MODE_PD_1K,
    DSWP_MODE_PD_100K,
    DSWP_MODE_PD_HIZ
  } dswp_mode_t;

  function automatic logic dswp_is_pd(input dswp_mode_t m);
    return m != DSWP_MODE_NORMAL;
  endfunction

endpackage

// ==== dswp_wake_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module dswp_wake_timer
  import dswp_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic start,
  input  wire logic cancel,
  output var  logic busy
);

  // ==========================================================================
  // wake-up countdown
  // ==========================================================================
  logic [11:0] cnt_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= 12'h000;
      busy    <= 1'b0;
    end
    else if (cancel)
    begin
      cnt_reg <= 12'h000;
      busy    <= 1'b0;
    end
    else if (start)
    begin
      cnt_reg <= DSWP_WAKE_UP_CYC_W;
      busy    <= 1'b1;
    end
    else if (cnt_reg != 12'h000)
    begin
      cnt_reg <= cnt_reg - 12'h001;
      busy    <= (cnt_reg != 12'h001);
    end
  end

endmodule // dswp_wake_timer
`default_nettype wire

// ==== dswp_core.sv ====
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dswp_core
  import dswp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        serial_clk,
  input  wire logic        serial_data,
  input  wire logic        frame_select_bar,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [11:0] dac_code,
  output var  logic [1:0]  op_mode,
  output var  logic        output_enable,
  output var  logic        frame_applied
);

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  logic [1:0] sclk_sync_reg;
  logic [1:0] sdat_sync_reg;
  logic [1:0] fsb_sync_reg;
  logic       sclk_d_reg;
  logic       fsb_d_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sclk_sync_reg <= 2'h0;
      sdat_sync_reg <= 2'h0;
      fsb_sync_reg  <= 2'h3;
      sclk_d_reg    <= 1'b0;
      fsb_d_reg     <= 1'b1;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[0], serial_clk};
      sdat_sync_reg <= {sdat_sync_reg[0], serial_data};
      fsb_sync_reg  <= {fsb_sync_reg[0], frame_select_bar};
      sclk_d_reg    <= sclk_sync_reg[1];
      fsb_d_reg     <= fsb_sync_reg[1];
    end
  end

  logic sclk_fall;
  logic fsb_rise;
  logic fsb_low;
  assign sclk_fall = sclk_d_reg & ~sclk_sync_reg[1];
  assign fsb_rise  = ~fsb_d_reg & fsb_sync_reg[1];
  assign fsb_low   = ~fsb_sync_reg[1];

  // ==========================================================================
  // frame shifter
  // ==========================================================================
  logic [15:0] shift_reg;
  logic [4:0]  bit_cnt_reg;
  logic        done_reg;
  logic        apply;
  logic [15:0] frame_word;
  logic        ctrl_clr_wr;

  // done blocks further edges until frame select has been high again
  assign apply      = fsb_low & sclk_fall & ~done_reg
                      & (bit_cnt_reg == DSWP_LAST_BIT - 5'h01);
  assign frame_word = {shift_reg[14:0], sdat_sync_reg[1]};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shift_reg   <= 16'h0000;
      bit_cnt_reg <= 5'h00;
      done_reg    <= 1'b0;
    end
    else if (!fsb_low)
    begin
      shift_reg   <= 16'h0000;
      bit_cnt_reg <= 5'h00;
      done_reg    <= 1'b0;
    end
    else if (sclk_fall && !done_reg)
    begin
      shift_reg   <= frame_word;
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      done_reg    <= apply;
    end
  end

  // ==========================================================================
  // applied state
  // ==========================================================================
  dswp_mode_t  mode_reg;
  logic        valid_reg;
  logic        abort_reg;
  logic        wake_busy;
  logic        wake_start;
  logic [15:0] frame_cnt_reg;

  assign wake_start = apply & dswp_is_pd(mode_reg)
                      & ~dswp_is_pd(dswp_mode_t'(frame_word[DSWP_MODE_HI:DSWP_MODE_LO]));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dac_code <= DSWP_CODE_RST;
      mode_reg <= DSWP_MODE_NORMAL;
    end
    else if (apply)
    begin
      // top two bits dropped on purpose
      mode_reg <= dswp_mode_t'(frame_word[DSWP_MODE_HI:DSWP_MODE_LO]);
      dac_code <= frame_word[DSWP_CODE_HI:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      valid_reg     <= 1'b0;
      abort_reg     <= 1'b0;
      frame_applied <= 1'b0;
      frame_cnt_reg <= 16'h0000;
    end
    else
    begin
      frame_applied <= apply;
      if (apply)
      begin
        valid_reg     <= 1'b1;
        frame_cnt_reg <= frame_cnt_reg + 16'h0001;
      end
      // set beats clear
      if (fsb_rise && bit_cnt_reg != 5'h00 && !done_reg)
        abort_reg <= 1'b1;
      else if (ctrl_clr_wr)
        abort_reg <= 1'b0;
    end
  end

  dswp_wake_timer u_wake (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (wake_start),
    .cancel  (apply & ~wake_start),
    .busy    (wake_busy)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      op_mode       <= 2'h0;
      output_enable <= 1'b0;
    end
    else
    begin
      op_mode       <= mode_reg;
      // amplifier live only when normal, written, and awake
      output_enable <= valid_reg & ~dswp_is_pd(mode_reg) & ~wake_busy;
    end
  end

  // ==========================================================================
  // axi4-lite slave
  // ==========================================================================
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_go;

  assign wr_go       = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign ctrl_clr_wr = wr_go & (aw_addr_reg == DSWP_CTRL_OFS)
                       & w_strb_reg[0] & w_data_reg[DSWP_CTRL_CLR_BIT];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 12'h000;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= DSWP_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[11:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg == DSWP_CTRL_OFS) ? DSWP_RESP_OKAY : DSWP_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic [31:0] rd_mux(input logic [11:0] a);
    unique case (a)
      DSWP_CTRL_OFS:   rd_mux = 32'h0000_0000;
      DSWP_STATUS_OFS: rd_mux = {27'h0, abort_reg, fsb_low, valid_reg,
                                 wake_busy, dswp_is_pd(mode_reg)};
      DSWP_CODE_OFS:   rd_mux = {20'h0, dac_code};
      DSWP_MODE_OFS:   rd_mux = {30'h0, mode_reg};
      DSWP_COUNT_OFS:  rd_mux = {16'h0, frame_cnt_reg};
      default:         rd_mux = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic rd_ok(input logic [11:0] a);
    return a <= DSWP_COUNT_OFS && a[1:0] == 2'h0;
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= DSWP_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok(s_axi_araddr[11:0]) ? rd_mux(s_axi_araddr[11:0]) : 32'h0000_0000;
        s_axi_rresp  <= rd_ok(s_axi_araddr[11:0]) ? DSWP_RESP_OKAY : DSWP_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  property p_idle_no_shift;
    @(posedge aclk) disable iff (!aresetn)
    !fsb_low |=> (bit_cnt_reg == 5'h00);
  endproperty
  a_idle_no_shift: assert property (p_idle_no_shift)
    else $error("shift count not cleared while frame select high");

  property p_count_step;
    @(posedge aclk) disable iff (!aresetn)
    (fsb_low && sclk_fall && !done_reg) |=> (bit_cnt_reg == $past(bit_cnt_reg) + 5'h01);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("bit count did not step on falling edge");

  property p_apply_at_16;
    @(posedge aclk) disable iff (!aresetn)
    apply |=> (bit_cnt_reg == DSWP_LAST_BIT) && done_reg;
  endproperty
  a_apply_at_16: assert property (p_apply_at_16)
    else $error("frame not applied at sixteenth edge");

  property p_code_load;
    @(posedge aclk) disable iff (!aresetn)
    apply |=> (dac_code == $past(frame_word[DSWP_CODE_HI:0])) && frame_applied;
  endproperty
  a_code_load: assert property (p_code_load)
    else $error("code not loaded from frame");

  property p_mode_load;
    @(posedge aclk) disable iff (!aresetn)
    apply |=> ##1 (op_mode == $past(frame_word[13:12], 2));
  endproperty
  a_mode_load: assert property (p_mode_load)
    else $error("mode output wrong after frame");

  property p_pd_off;
    @(posedge aclk) disable iff (!aresetn)
    dswp_is_pd(mode_reg) |=> !output_enable;
  endproperty
  a_pd_off: assert property (p_pd_off)
    else $error("output enabled in power-down");

  property p_no_write_zero;
    @(posedge aclk) disable iff (!aresetn)
    !valid_reg |-> (dac_code == 12'h000) && !output_enable;
  endproperty
  a_no_write_zero: assert property (p_no_write_zero)
    else $error("output not zero before first frame");

  property p_abort_keeps;
    @(posedge aclk) disable iff (!aresetn)
    (!fsb_low && !apply) |=> $stable(dac_code) && $stable(mode_reg);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps)
    else $error("state changed without a complete frame");

endmodule // dswp_core
`default_nettype wire

// ==== dswp_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// host end of the three-wire link
// ==========================================================================
module dswp_host_model
(
  output var logic serial_clk,
  output var logic serial_data,
  output var logic frame_select_bar
);
  localparam int HALF_NS = 80;

  initial
  begin
    serial_clk       = 1'b0;
    serial_data      = 1'b0;
    frame_select_bar = 1'b0;
  end

  // edges below 16 abort the frame; split pauses between two bytes
  task automatic frame(input logic [15:0] word, input int edges, input bit split);
    // keep pin changes clear of the sampling clock edge
    #2;
    frame_select_bar = 1'b1;
    #100;
    frame_select_bar = 1'b0;
    for (int i = 0; i < edges; i++)
    begin
      if (split && i == 8)
        #400;
      serial_clk  = 1'b1;
      serial_data = word[15-i];
      #HALF_NS;
      serial_clk = 1'b0;
      #HALF_NS;
    end
    if (edges < 16)
    begin
      frame_select_bar = 1'b1;
      #100;
    end
    frame_select_bar = 1'b0;
    serial_data      = 1'b0;
  endtask

  // clock and data toggling with frame select high
  task automatic stray(input int n);
    #2;
    frame_select_bar = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      serial_clk  = 1'b1;
      serial_data = ~serial_data;
      #HALF_NS;
      serial_clk = 1'b0;
      #HALF_NS;
    end
    frame_select_bar = 1'b0;
    serial_data      = 1'b0;
  endtask
endmodule // dswp_host_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dswp_pkg::*;
;
  logic        aclk, aresetn, serial_clk, serial_data, frame_select_bar;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, op_mode;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, output_enable, frame_applied;
  logic [11:0] dac_code;
  int          errors = 0;
  int          compares = 0;
  int          fa_cnt = 0;

  dswp_core dut (.aclk, .aresetn, .serial_clk, .serial_data, .frame_select_bar,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .dac_code, .op_mode, .output_enable, .frame_applied);

  dswp_host_model host (.serial_clk, .serial_data, .frame_select_bar);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk)
    if (frame_applied === 1'b1)
      fa_cnt <= fa_cnt + 1;

  // ========================================================================
  // checking and closing
  // ========================================================================
  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic timeout(input string what);
    errors++;
    $display("Error %s expected done seen timeout", what);
    close_out();
  endtask

  // ========================================================================
  // register bus
  // ========================================================================
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw;
    bit w;
    aw = 1'b1;
    w  = 1'b1;
    @(posedge aclk);
    s_axi_awaddr  <= {20'h00000, a};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1)
      begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    timeout("write");
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= {20'h00000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    timeout("read");
  endtask

  // masked register read compared with an expected value
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check(what, d & m, exp);
  endtask

  task automatic wait_fa(input int n);
    for (int i = 0; i < 200; i++)
    begin
      if (fa_cnt == n)
        return;
      @(posedge aclk);
    end
    timeout("frame_applied");
  endtask

  // ========================================================================
  // tests
  // ========================================================================
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [1:0]  md;
    aresetn       = 1'b0;
    s_axi_awaddr  = 32'h00000000;
    s_axi_wdata   = 32'h00000000;
    s_axi_araddr  = 32'h00000000;
    s_axi_wstrb   = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);

    check("dac_code", 32'(dac_code), 32'h00000000);
    check("output_enable", 32'(output_enable), 32'h00000000);
    rd_chk("status valid", DSWP_STATUS_OFS, 32'h00000004, 32'h00000000);
    rd_chk("status fsb low", DSWP_STATUS_OFS, 32'h00000008, 32'h00000008);
    axi_rd(12'h014, d, r);
    check("unmapped rresp", 32'(r), 32'(DSWP_RESP_SLVERR));
    axi_wr(DSWP_CODE_OFS, 32'h00000123, r);
    check("code write bresp", 32'(r), 32'(DSWP_RESP_SLVERR));
    $display("test reset done");

    // don't-care bits set to ones must not disturb mode or code
    host.frame(16'hCABC, 16, 1'b0);
    wait_fa(1);
    check("dac_code", 32'(dac_code), 32'h00000ABC);
    check("op_mode", 32'(op_mode), 32'(DSWP_MODE_NORMAL));
    rd_chk("code reg", DSWP_CODE_OFS, 32'h00000FFF, 32'h00000ABC);
    for (int i = 0; i < 5000 && output_enable !== 1'b1; i++)
      @(posedge aclk);
    check("output_enable", 32'(output_enable), 32'h00000001);
    $display("test frame done");

    for (int k = 1; k < 4; k++)
    begin
      md = 2'(k);
      host.frame({2'b01, md, 12'hABC}, 16, 1'b0);
      wait_fa(k + 1);
      repeat (2) @(posedge aclk);
      check("op_mode", 32'(op_mode), 32'(md));
      check("output_enable", 32'(output_enable), 32'h00000000);
      check("dac_code", 32'(dac_code), 32'h00000ABC);
      rd_chk("status pd", DSWP_STATUS_OFS, 32'h00000001, 32'h00000001);
      rd_chk("mode reg", DSWP_MODE_OFS, 32'h00000003, 32'(md));
    end
    $display("test modes done");

    // wake-up is 3900 cycles; the amplifier stays off meanwhile
    host.frame(16'h0ABC, 16, 1'b0);
    wait_fa(5);
    rd_chk("status wake", DSWP_STATUS_OFS, 32'h00000001 << DSWP_ST_WAKE_BIT,
           32'h00000001 << DSWP_ST_WAKE_BIT);
    repeat (3700) @(posedge aclk);
    check("output_enable early", 32'(output_enable), 32'h00000000);
    for (int i = 0; i < 400 && output_enable !== 1'b1; i++)
      @(posedge aclk);
    check("output_enable woke", 32'(output_enable), 32'h00000001);
    check("dac_code", 32'(dac_code), 32'h00000ABC);
    $display("test wake done");

    host.frame(16'h0555, 10, 1'b0);
    repeat (30) @(posedge aclk);
    check("dac_code", 32'(dac_code), 32'h00000ABC);
    check("op_mode", 32'(op_mode), 32'(DSWP_MODE_NORMAL));
    check("frames", 32'(fa_cnt), 32'd5);
    rd_chk("abort flag", DSWP_STATUS_OFS, 32'h00000010, 32'h00000010);
    axi_wr(DSWP_CTRL_OFS, 32'h00000001, r);
    check("ctrl bresp", 32'(r), 32'(DSWP_RESP_OKAY));
    rd_chk("abort flag", DSWP_STATUS_OFS, 32'h00000010, 32'h00000000);
    $display("test abort done");

    host.stray(16);
    repeat (30) @(posedge aclk);
    check("frames", 32'(fa_cnt), 32'd5);
    check("dac_code", 32'(dac_code), 32'h00000ABC);
    $display("test stray done");

    host.frame(16'h0FFF, 16, 1'b1);
    wait_fa(6);
    check("dac_code", 32'(dac_code), 32'h00000FFF);
    host.frame(16'h0000, 16, 1'b0);
    wait_fa(7);
    check("dac_code", 32'(dac_code), 32'h00000000);
    rd_chk("count reg", DSWP_COUNT_OFS, 32'h0000FFFF, 32'd7);
    $display("test bytes done");
    close_out();
  end
endmodule // testbench
`default_nettype wire
